// *** hw/ascs_pkg.sv ***
// Constants, encodings and carriers of the auto speed change scheduler.
// Assumes one AHB-Lite master and a pulse engine per channel outside the block.
package ascs_pkg;
  localparam int ASCS_NCH = 16;
  localparam int ASCS_DEPTH = 128;
  localparam logic [7:0] ASCS_OFF_CTRL = 8'h00;
  localparam logic [7:0] ASCS_OFF_SEL = 8'h04;
  localparam logic [7:0] ASCS_OFF_TRIG = 8'h08;
  localparam logic [7:0] ASCS_OFF_TVAL = 8'h0c;
  localparam logic [7:0] ASCS_OFF_PARAM = 8'h10;
  localparam logic [7:0] ASCS_OFF_CMD = 8'h14;
  localparam logic [7:0] ASCS_OFF_STATUS = 8'h18;
  localparam logic [7:0] ASCS_OFF_QSEL = 8'h1c;
  localparam logic [7:0] ASCS_OFF_QTRIG = 8'h20;
  localparam logic [7:0] ASCS_OFF_QTVAL = 8'h24;
  localparam logic [7:0] ASCS_OFF_QPARAM = 8'h28;
  localparam logic [7:0] ASCS_OFF_RUN = 8'h2c;
  localparam logic [7:0] ASCS_OFF_RATE = 8'h30;
  localparam int ASCS_SEL_IDX_LSB = 8;
  localparam int ASCS_TRIG_ACT_LSB = 8;
  localparam int ASCS_CMD_CH_LSB = 8;
  localparam int ASCS_CMD_SCURVE_BIT = 16;
  localparam int ASCS_ST_HOLD_BIT = 16;
  localparam int ASCS_ST_QVALID_BIT = 17;
  localparam int ASCS_ST_ERR_BIT = 18;
  localparam logic [31:0] ASCS_POS_BAD = 32'h80000000;
  localparam logic [31:0] ASCS_TIME_MAX = 32'h0000ffff;
  localparam logic [31:0] ASCS_SPEED_MAX = 32'h004c4b40;
  localparam logic [6:0] ASCS_RATE_MAX = 7'h73;
  localparam logic [6:0] ASCS_RST_RATE = 7'h00;
  localparam logic [6:0] ASCS_GRP_LO [6] = '{7'h00, 7'h11, 7'h18, 7'h1f, 7'h29, 7'h37};
  localparam logic [6:0] ASCS_GRP_HI [6] = '{7'h3c, 7'h4c, 7'h54, 7'h5b, 7'h64, 7'h73};

  typedef enum logic [2:0] {
    trig_end = 3'h0, trig_position_offset = 3'h1, elapsed_time_trigger = 3'h2,
    accel_speed_trigger = 3'h3, decel_speed_trigger = 3'h4
  } ascs_trig_type;
  typedef enum logic [2:0] {
    set_speed_action = 3'h0, set_rate_action = 3'h1, slow_stop_action = 3'h2,
    fast_stop_action = 3'h3, skip_action = 3'h7
  } ascs_act_type;
  typedef enum logic [3:0] {
    cmd_none = 4'h0, schedule_entry_write = 4'h1, schedule_entry_query = 4'h2,
    schedule_arm_cmd = 4'h3, absolute_move_cmd = 4'h4, relative_move_cmd = 4'h5,
    positive_scan_cmd = 4'h6, negative_scan_cmd = 4'h7, schedule_disarm_cmd = 4'h8,
    legacy_start_hold_cmd = 4'h9, legacy_start_release_cmd = 4'ha,
    channel_slow_stop_cmd = 4'hb, channel_fast_stop_cmd = 4'hc, all_slow_stop_cmd = 4'hd,
    all_fast_stop_cmd = 4'he, rate_set_cmd = 4'hf
  } ascs_op_type;
  typedef struct packed {
    logic [2:0] kind;
    logic [31:0] tval;
    logic [2:0] act;
    logic [31:0] param;
  } ascs_entry_type;
  typedef struct packed {
    logic [1:0] kind;
    logic [31:0] target;
  } ascs_move_type;
endpackage

// *** hw/ascs_scheduler.sv ***
// Schedule store, arming and synchronous start logic for 16 motor channels.
// Assumes an AHB-Lite master and a pulse engine that executes started moves.
`timescale 1ns/1ps
module ascs_scheduler #(
  parameter int DEPTH = ascs_pkg::ASCS_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [ascs_pkg::ASCS_NCH-1:0] move_done,
  output logic [ascs_pkg::ASCS_NCH-1:0] start_pulse,
  output logic [ascs_pkg::ASCS_NCH-1:0] sched_run,
  output logic [ascs_pkg::ASCS_NCH-1:0] scurve_profile,
  output logic [ascs_pkg::ASCS_NCH-1:0] slow_stop,
  output logic [ascs_pkg::ASCS_NCH-1:0] fast_stop,
  output ascs_pkg::ascs_move_type [ascs_pkg::ASCS_NCH-1:0] move_cmd
);
  import ascs_pkg::*;
  localparam int IW = $clog2(DEPTH);
  localparam int NCH = ASCS_NCH;

  logic wr_pend_q, remote_q, hold_q, err_q, qvalid_q;
  logic [7:0] wr_addr_q, sel_idx_q, q_idx_q;
  logic [3:0] sel_ch_q, q_ch_q;
  logic [2:0] trig_q, act_q;
  logic [31:0] tval_q, param_q;
  ascs_entry_type q_entry_q;
  ascs_entry_type table_mem [NCH*DEPTH];
  logic [NCH-1:0] ready_q, term_q, pend_q;
  logic [NCH-1:0][6:0] rate_q;

  // Bus address phase and register read selection.
  wire addr_ok = hsel && hready && htrans[1];
  wire [7:0] ra = haddr[7:0];
  wire [31:0] st_word = {13'h0, err_q, qvalid_q, hold_q, ready_q};
  wire [31:0] rd_d =
    (ra == ASCS_OFF_CTRL) ? {31'h0, remote_q} :
    (ra == ASCS_OFF_SEL) ? {16'h0, sel_idx_q, 4'h0, sel_ch_q} :
    (ra == ASCS_OFF_TRIG) ? {21'h0, act_q, 5'h0, trig_q} :
    (ra == ASCS_OFF_TVAL) ? tval_q :
    (ra == ASCS_OFF_PARAM) ? param_q :
    (ra == ASCS_OFF_STATUS) ? st_word :
    (ra == ASCS_OFF_QSEL) ? {16'h0, q_idx_q, 4'h0, q_ch_q} :
    (ra == ASCS_OFF_QTRIG) ? {21'h0, q_entry_q.act, 5'h0, q_entry_q.kind} :
    (ra == ASCS_OFF_QTVAL) ? q_entry_q.tval :
    (ra == ASCS_OFF_QPARAM) ? q_entry_q.param :
    (ra == ASCS_OFF_RUN) ? {sched_run, pend_q} :
    (ra == ASCS_OFF_RATE) ? {25'h0, rate_q[sel_ch_q]} : 32'h0;

  // Data phase write decode.
  wire wsel = wr_pend_q;
  wire w_ctrl = wsel && wr_addr_q == ASCS_OFF_CTRL;
  wire w_cmd = wsel && wr_addr_q == ASCS_OFF_CMD;
  wire [3:0] cch = hwdata[ASCS_CMD_CH_LSB+:4];
  wire csc = hwdata[ASCS_CMD_SCURVE_BIT];
  wire [NCH-1:0] chot = 16'h0001 << cch;
  ascs_op_type op;
  assign op = ascs_op_type'(hwdata[3:0]);
  wire rcmd = w_cmd && remote_q;

  // Entry validation against the selected channel's current rate.
  function automatic logic [2:0] grp_of(input logic [6:0] r);
    logic [2:0] g;
    g = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (r >= ASCS_GRP_LO[i]) begin
        g = 3'(i);
      end
    end
    return g;
  endfunction
  wire [2:0] grp = grp_of(rate_q[sel_ch_q]);
  wire [31:0] grp_lo = {25'h0, ASCS_GRP_LO[grp]};
  wire [31:0] grp_hi = {25'h0, ASCS_GRP_HI[grp]};
  wire idx_ok = 32'(sel_idx_q) < DEPTH;
  wire tv_spd = tval_q != 32'h0 && tval_q <= ASCS_SPEED_MAX;
  wire pa_spd = param_q != 32'h0 && param_q <= ASCS_SPEED_MAX;
  wire is_end = trig_q == trig_end;
  wire tval_ok = is_end ? 1'b1 :
    (trig_q == trig_position_offset) ? tval_q != ASCS_POS_BAD :
    (trig_q == elapsed_time_trigger) ? tval_q <= ASCS_TIME_MAX :
    (trig_q == accel_speed_trigger || trig_q == decel_speed_trigger) ? tv_spd : 1'b0;
  wire par_ok = is_end ? 1'b1 :
    (act_q == set_speed_action) ? pa_spd :
    (act_q == set_rate_action) ? (param_q >= grp_lo && param_q <= grp_hi) :
    (act_q == slow_stop_action || act_q == fast_stop_action || act_q == skip_action);
  wire ent_we = rcmd && op == schedule_entry_write && idx_ok && tval_ok && par_ok;
  wire qry_v = w_cmd && op == schedule_entry_query && idx_ok;
  wire arm_v = rcmd && op == schedule_arm_cmd && term_q[cch];
  wire dis_v = rcmd && op == schedule_disarm_cmd;
  wire mv_v = rcmd && hwdata[3:2] == 2'b01;
  wire hold_v = rcmd && op == legacy_start_hold_cmd;
  wire rel_v = rcmd && op == legacy_start_release_cmd;
  wire rate_v = rcmd && op == rate_set_cmd && param_q <= {25'h0, ASCS_RATE_MAX};
  wire [NCH-1:0] slow_hot = ((rcmd && op == channel_slow_stop_cmd) ? chot : '0) |
    {NCH{rcmd && op == all_slow_stop_cmd}};
  wire [NCH-1:0] fast_hot = ((rcmd && op == channel_fast_stop_cmd) ? chot : '0) |
    {NCH{rcmd && op == all_fast_stop_cmd}};
  wire cmd_ok = ent_we || qry_v || arm_v || dis_v || mv_v || hold_v || rel_v || rate_v ||
    (|slow_hot) || (|fast_hot);
  wire [NCH-1:0] start_v = ((mv_v && !hold_q) ? chot : '0) | (rel_v ? pend_q : '0);
  ascs_move_type new_move;
  assign new_move = '{kind: hwdata[1:0], target: tval_q};

  // Bus slave registers, zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= addr_ok ? ra : wr_addr_q;
      hrdata <= (addr_ok && !hwrite) ? rd_d : 32'h0;
    end
  end

  // Staging registers and command results.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remote_q <= 1'b0;
      sel_ch_q <= 4'h0;
      sel_idx_q <= 8'h00;
      trig_q <= 3'h0;
      act_q <= 3'h0;
      tval_q <= 32'h0;
      param_q <= 32'h0;
      hold_q <= 1'b0;
      err_q <= 1'b0;
      qvalid_q <= 1'b0;
      q_ch_q <= 4'h0;
      q_idx_q <= 8'h00;
    end else begin
      remote_q <= w_ctrl ? hwdata[0] : remote_q;
      if (wsel && wr_addr_q == ASCS_OFF_SEL) begin
        sel_ch_q <= hwdata[3:0];
        sel_idx_q <= hwdata[ASCS_SEL_IDX_LSB+:8];
      end
      if (wsel && wr_addr_q == ASCS_OFF_TRIG) begin
        trig_q <= hwdata[2:0];
        act_q <= hwdata[ASCS_TRIG_ACT_LSB+:3];
      end
      tval_q <= (wsel && wr_addr_q == ASCS_OFF_TVAL) ? hwdata : tval_q;
      param_q <= (wsel && wr_addr_q == ASCS_OFF_PARAM) ? hwdata : param_q;
      hold_q <= hold_v ? 1'b1 : (rel_v ? 1'b0 : hold_q);
      err_q <= w_cmd ? !cmd_ok : err_q;
      qvalid_q <= qry_v ? 1'b1 : qvalid_q;
      if (qry_v) begin
        q_ch_q <= sel_ch_q;
        q_idx_q <= sel_idx_q;
      end
    end
  end

  // Schedule tables, one per channel, kept until rewritten.
  always_ff @(posedge hclk) begin
    if (ent_we) begin
      table_mem[{sel_ch_q, sel_idx_q[IW-1:0]}] <= '{trig_q, tval_q, act_q, param_q};
    end
    if (qry_v) begin
      q_entry_q <= table_mem[{sel_ch_q, sel_idx_q[IW-1:0]}];
    end
  end

  // Per-channel arming, deferral and move launch.
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic rdy_q, term_c_q, pend_c_q, run_q, scv_q, st_q, ss_q, fs_q, pscv_q;
    logic [6:0] rt_q;
    logic [IW-1:0] end_q;
    ascs_move_type mv_q, pmv_q;
    wire hit = cch == 4'(c);
    wire wr_c = ent_we && sel_ch_q == 4'(c);
    wire stop_c = slow_hot[c] || fast_hot[c];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rdy_q <= 1'b0;
        term_c_q <= 1'b0;
        end_q <= '0;
        pend_c_q <= 1'b0;
        run_q <= 1'b0;
        scv_q <= 1'b0;
        st_q <= 1'b0;
        ss_q <= 1'b0;
        fs_q <= 1'b0;
        pscv_q <= 1'b0;
        rt_q <= ASCS_RST_RATE;
        mv_q <= '0;
        pmv_q <= '0;
      end else begin
        st_q <= start_v[c];
        ss_q <= slow_hot[c];
        fs_q <= fast_hot[c];
        if (arm_v && hit) begin
          rdy_q <= 1'b1;
        end else if (wr_c || (dis_v && hit) || start_v[c]) begin
          rdy_q <= 1'b0;
        end
        if (wr_c && is_end) begin
          term_c_q <= 1'b1;
          end_q <= sel_idx_q[IW-1:0];
        end else if (wr_c && sel_idx_q[IW-1:0] >= end_q) begin
          term_c_q <= 1'b0;
        end
        if (start_v[c]) begin
          run_q <= rdy_q;
          scv_q <= (rel_v ? pscv_q : csc) && !rdy_q;
          mv_q <= rel_v ? pmv_q : new_move;
        end else if (stop_c || move_done[c]) begin
          run_q <= 1'b0;
        end
        if (mv_v && hit && hold_q) begin
          pend_c_q <= 1'b1;
          pmv_q <= new_move;
          pscv_q <= csc;
        end else if (rel_v || stop_c) begin
          pend_c_q <= 1'b0;
        end
        rt_q <= (rate_v && hit) ? param_q[6:0] : rt_q;
      end
    end
    assign ready_q[c] = rdy_q;
    assign term_q[c] = term_c_q;
    assign pend_q[c] = pend_c_q;
    assign rate_q[c] = rt_q;
    assign start_pulse[c] = st_q;
    assign sched_run[c] = run_q;
    assign scurve_profile[c] = scv_q;
    assign slow_stop[c] = ss_q;
    assign fast_stop[c] = fs_q;
    assign move_cmd[c] = mv_q;
  end

  // Checks on the scheduling behaviour.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  local_write_a: assert property (w_cmd && !remote_q |=> ready_q == $past(ready_q))
    else $error("Local-mode command changed ready flags.");
  arm_refused_a: assert property (w_cmd && op == schedule_arm_cmd && !term_q[cch]
    && !ready_q[cch] |=> !ready_q[$past(cch)])
    else $error("Unterminated list was armed.");
  write_clear_a: assert property (ent_we |=> !ready_q[$past(sel_ch_q)])
    else $error("Entry write left channel armed.");
  disarm_one_a: assert property (dis_v |=> ready_q == ($past(ready_q) & ~$past(chot)))
    else $error("Disarm touched another channel.");
  sched_start_a: assert property (start_v != '0 |=> start_pulse == $past(start_v)
    && ((sched_run ^ $past(ready_q)) & $past(start_v)) == '0
    && (ready_q & $past(start_v)) == '0)
    else $error("Start did not follow ready flags.");
  hold_defer_a: assert property (hold_q && !rel_v |=> start_pulse == '0)
    else $error("Move started during pause hold.");
  all_stop_a: assert property (rcmd && op == all_fast_stop_cmd |=> fast_stop == '1
    && sched_run == '0 ##1 fast_stop == '0)
    else $error("All-channel fast stop not applied.");
  rate_group_a: assert property (rcmd && op == schedule_entry_write && !is_end
    && act_q == set_rate_action && (param_q < grp_lo || param_q > grp_hi)
    |=> err_q && ready_q == $past(ready_q))
    else $error("Rate change outside current group.");
  bad_entry_a: assert property (rcmd && op == schedule_entry_write && !tval_ok
    |=> err_q && ready_q == $past(ready_q))
    else $error("Bad entry not rejected.");
  query_a: assert property (qry_v |=> qvalid_q && q_ch_q == $past(sel_ch_q))
    else $error("Query echo wrong.");
  trapezoid_a: assert property ((start_v & ready_q) != '0
    |=> (scurve_profile & $past(start_v & ready_q)) == '0)
    else $error("Scheduled move kept S-curve profile.");

  arm_start_c: cover property (arm_v ##[1:20] (start_v != '0));
  hold_release_c: cover property (hold_v ##[1:20] rel_v && $countones(pend_q) > 1);
  local_query_c: cover property (qry_v && !remote_q);
endmodule

// *** tb/ascs_engine_model.sv ***
// Pulse engine stand-in: runs each started move and reports when it runs out; a move stopped before its last count reports nothing.
// Assumes the scheduler's start and stop pulses on one clock.
`timescale 1ns/1ps
module ascs_engine_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic [15:0] start_pulse,
  input wire logic [15:0] stop_pulse,
  output logic [15:0] move_done
);
  logic [7:0] left_q [16];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      move_done <= 16'h0000;
      for (int c = 0; c < 16; c++) left_q[c] <= 8'h00;
    end else begin
      for (int c = 0; c < 16; c++) begin
        move_done[c] <= (left_q[c] == 8'h01);
        if (start_pulse[c]) left_q[c] <= slow ? 8'hc8 : 8'h03;
        else if (stop_pulse[c]) left_q[c] <= 8'h00; // Stops end the move at once.
        else if (left_q[c] != 8'h00) left_q[c] <= left_q[c] - 8'h01;
      end
    end
  end
endmodule

// *** tb/tb_auto_speed_change_scheduler.sv ***
// Self-checking bench of the schedule store, arming and synchronous start.
// Assumes the scheduler as the only AHB-Lite slave and the engine model beside it.
`timescale 1ns/1ps
module tb_auto_speed_change_scheduler;
  import ascs_pkg::*;
  localparam logic [2:0] BK [7] = '{3'h5, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h1};
  localparam logic [2:0] BA [7] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  localparam logic [31:0] BT [7] = '{32'h1, 32'h1, 32'h10000, 32'h0, 32'h4c4b41,
                                     32'h80000000, 32'h1};
  localparam logic [31:0] BP [7] = '{32'h64, 32'h64, 32'h64, 32'h64, 32'h64, 32'h64, 32'h0};
  localparam logic [6:0] RN [4] = '{7'h1e, 7'h1f, 7'h5b, 7'h5c};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, slow = 1'b1;
  logic hready, hresp;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [15:0] move_done, start_pulse, sched_run, scurve_profile, slow_stop, fast_stop;
  logic [15:0] st_acc = 16'h0, sp_acc = 16'h0;
  int st_cyc = 0, cyc = 0, fail_count = 0, num_checks = 0;
  ascs_move_type [15:0] move_cmd;
  always #20 hclk = ~hclk;
  ascs_scheduler ascs_scheduler_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .move_done(move_done), .start_pulse(start_pulse), .sched_run(sched_run),
    .scurve_profile(scurve_profile), .slow_stop(slow_stop), .fast_stop(fast_stop),
    .move_cmd(move_cmd));
  ascs_engine_model ascs_engine_model_i (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .start_pulse(start_pulse), .stop_pulse(slow_stop | fast_stop), .move_done(move_done));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (start_pulse !== 16'h0) st_cyc <= st_cyc + 1;
    st_acc <= st_acc | start_pulse;
    sp_acc <= sp_acc | slow_stop | fast_stop;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One single transfer with an idle cycle ahead of it.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] ch, input logic sc = 1'b0);
    xfer(1'b1, ASCS_OFF_CMD, {15'h0, sc, 4'h0, ch, 4'h0, op});
  endtask
  task automatic ent(input logic [3:0] ch, input logic [7:0] ix, input logic [2:0] k,
                     input logic [31:0] tv, input logic [2:0] ac, input logic [31:0] pr);
    xfer(1'b1, ASCS_OFF_SEL, {16'h0, ix, 4'h0, ch});
    xfer(1'b1, ASCS_OFF_TRIG, {21'h0, ac, 5'h0, k});
    xfer(1'b1, ASCS_OFF_TVAL, tv);
    xfer(1'b1, ASCS_OFF_PARAM, pr);
    cmd(schedule_entry_write, ch);
  endtask
  task automatic stat(input logic [15:0] rdy, input logic err);
    xfer(1'b0, ASCS_OFF_STATUS, 32'h0);
    check("ready", {16'h0, rd[15:0]}, {16'h0, rdy});
    check("error", {31'h0, rd[18]}, {31'h0, err});
    check("response", {30'h0, hready, hresp}, 32'h2);
  endtask
  // Accepted rate: inside the highest group whose low bound the current rate reaches.
  function automatic logic rate_ok(input logic [6:0] cur, input logic [6:0] nw);
    int g;
    g = 0;
    for (int i = 0; i < 6; i++) if (ASCS_GRP_LO[i] <= cur) g = i;
    return nw >= ASCS_GRP_LO[g] && nw <= ASCS_GRP_HI[g];
  endfunction
  initial begin
    logic [3:0] ch;
    logic [7:0] ix;
    logic [31:0] tv, pr;
    void'($urandom(95382));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    stat(16'h0, 1'b0);
    xfer(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    ent(4'h0, 8'h0, trig_end, 32'h0, skip_action, 32'h0);
    stat(16'h0, 1'b1);
    cmd(schedule_entry_query, 4'h0);
    stat(16'h0, 1'b0);
    xfer(1'b1, ASCS_OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ch = 4'($urandom());
      ix = {1'b0, 7'($urandom())};
      tv = $urandom() & 32'hffff;
      pr = 32'h1 + ($urandom() % ASCS_SPEED_MAX);
      ent(ch, ix, elapsed_time_trigger, tv, set_speed_action, pr);
      cmd(schedule_entry_query, ch);
      xfer(1'b0, ASCS_OFF_QSEL, 32'h0);
      check("qsel", rd, {16'h0, ix, 4'h0, ch});
      xfer(1'b0, ASCS_OFF_QTRIG, 32'h0);
      check("qtrig", rd, {21'h0, set_speed_action, 5'h0, elapsed_time_trigger});
      xfer(1'b0, ASCS_OFF_QTVAL, 32'h0);
      check("qtval", rd, tv);
      xfer(1'b0, ASCS_OFF_QPARAM, 32'h0);
      check("qparam", rd, pr);
    end
    ent(4'h0, 8'h0, trig_position_offset, 32'h1388, set_speed_action, 32'hbb8);
    ent(4'h0, 8'h1, trig_end, 32'h0, skip_action, 32'h0);
    cmd(schedule_arm_cmd, 4'h0);
    stat(16'h1, 1'b0);
    for (int i = 0; i < 7; i++) begin
      ent(4'h0, 8'h0, BK[i], BT[i], BA[i], BP[i]);
      stat(16'h1, 1'b1);
    end
    ent(4'h0, 8'h80, trig_end, 32'h0, skip_action, 32'h0);
    stat(16'h1, 1'b1);
    ent(4'h1, 8'h0, trig_position_offset, 32'h64, fast_stop_action, 32'h0);
    cmd(schedule_arm_cmd, 4'h1);
    stat(16'h1, 1'b1);
    ent(4'h0, 8'h0, trig_position_offset, 32'hffffec78, slow_stop_action, 32'h0);
    stat(16'h0, 1'b0);
    xfer(1'b1, ASCS_OFF_PARAM, 32'h1f);
    cmd(rate_set_cmd, 4'h0);
    xfer(1'b0, ASCS_OFF_RATE, 32'h0);
    check("rate", rd, 32'h1f);
    for (int i = 0; i < 4; i++) begin
      ent(4'h0, 8'h0, trig_position_offset, 32'h64, set_rate_action, {25'h0, RN[i]});
      stat(16'h0, !rate_ok(7'h1f, RN[i]));
    end
    ent(4'h3, 8'h0, elapsed_time_trigger, 32'h0, set_speed_action, 32'h3e8);
    ent(4'h3, 8'h1, trig_end, 32'h0, skip_action, 32'h0);
    cmd(schedule_arm_cmd, 4'h0);
    cmd(schedule_arm_cmd, 4'h3);
    stat(16'h9, 1'b0);
    cmd(schedule_disarm_cmd, 4'h3);
    stat(16'h1, 1'b0);
    cmd(legacy_start_hold_cmd, 4'h0);
    xfer(1'b1, ASCS_OFF_TVAL, 32'h4d2);
    @(negedge hclk);
    st_acc = 16'h0;
    st_cyc = 0;
    cmd(absolute_move_cmd, 4'h0, 1'b1);
    cmd(relative_move_cmd, 4'h2);
    repeat (3) @(posedge hclk);
    check("held", {16'h0, st_acc}, 32'h0);
    xfer(1'b0, ASCS_OFF_RUN, 32'h0);
    check("pending", rd, 32'h5);
    cmd(legacy_start_release_cmd, 4'h0);
    repeat (3) @(posedge hclk);
    check("starts", {16'h0, st_acc}, 32'h5);
    check("start cycles", 32'(st_cyc), 32'h1);
    check("sched", {16'h0, sched_run}, 32'h1);
    check("scurve", {31'h0, scurve_profile[0]}, 32'h0);
    check("target", move_cmd[0].target, 32'h4d2);
    check("kind", {30'h0, move_cmd[2].kind}, 32'h1);
    stat(16'h0, 1'b0);
    @(negedge hclk);
    sp_acc = 16'h0;
    cmd(channel_slow_stop_cmd, 4'h0);
    repeat (2) @(posedge hclk);
    check("stop", {31'h0, sp_acc[0]}, 32'h1);
    check("sched", {31'h0, sched_run[0]}, 32'h0);
    cmd(schedule_arm_cmd, 4'h0);
    cmd(positive_scan_cmd, 4'h0);
    repeat (2) @(posedge hclk);
    check("scan", {31'h0, sched_run[0]}, 32'h1);
    @(negedge hclk);
    sp_acc = 16'h0;
    cmd(all_fast_stop_cmd, 4'h0);
    repeat (2) @(posedge hclk);
    check("sched", {31'h0, sched_run[0]}, 32'h0);
    check("all stop", {16'h0, sp_acc}, 32'hffff);
    slow <= 1'b0;
    cmd(negative_scan_cmd, 4'h4, 1'b1);
    repeat (12) @(posedge hclk);
    check("kind", {30'h0, move_cmd[4].kind}, 32'h3);
    check("scurve", {31'h0, scurve_profile[4]}, 32'h1);
    check("sched", {31'h0, sched_run[4]}, 32'h0);
    xfer(1'b1, ASCS_OFF_CTRL, 32'h0);
    cmd(schedule_arm_cmd, 4'h0);
    stat(16'h0, 1'b1);
    close_out();
  end
endmodule
